//--- logic/jbf_pkg.sv
// Shared constants for the 64B/66B block framer with CRC-12 sync header stream.
// Assumes a transport layer that hands over one 8-octet block per enabled clock.
package jbf_pkg;

  // Block layout.
  localparam int OCTETS      = 8;
  localparam int PAYLOAD_W   = 64;
  localparam int SH_W        = 2;
  localparam int TXBLK_W     = 66;
  localparam int SH_POS      = 0;
  localparam int OCTET0_POS  = 2;

  // Multiblock and sync header stream.
  localparam int MB_BLOCKS   = 32;
  localparam int BLK_W       = 5;
  localparam logic [BLK_W-1:0] BLK_LAST = 5'h1f;
  localparam int SHS_W       = 32;
  localparam int POS_EOEMB   = 22;
  localparam int POS_EOMB    = 31;
  localparam int EOMB_ZEROS  = 4;

  // Parity word.
  localparam int CRC_W                 = 12;
  localparam logic [CRC_W-1:0] CRC_POLY = 12'h987;
  localparam logic [CRC_W-1:0] CRC_INIT = 12'h000;
  localparam int CRC_GROUPS            = 4;
  localparam int CRC_GROUP_BITS        = 3;
  localparam int CRC_GROUP_STRIDE      = 4;

  // Fixed pilot ones, end-of-multiblock one and zero command bits.
  localparam logic [SHS_W-1:0] SHS_CRC12_TMPL = 32'h80a8_8888;
  localparam logic [SHS_W-1:0] SHS_FEC_TMPL   = 32'h8000_0000;
  localparam logic [SHS_W-1:0] SHS_CMD_MASK   = 32'h0717_0000;

  // Header stream format codes.
  localparam int FMT_W                    = 2;
  localparam logic [FMT_W-1:0] FMT_CRC12  = 2'h0;
  localparam logic [FMT_W-1:0] FMT_FEC    = 2'h2;

  // Scrambler taps, counted in past scrambled bits.
  localparam int SCR_W     = 58;
  localparam int SCR_TAP_A = 39;
  localparam int SCR_TAP_B = 58;

endpackage

//--- logic/jbf_crc12_step.sv
// Parallel form of the serial CRC-12 parity register, one block per call.
// Assumes the caller clears the running value at each multiblock border.
`timescale 1ns/10ps
module jbf_crc12_step #(
  parameter int DW = jbf_pkg::PAYLOAD_W
) (
  // Running parity and data
  input  wire logic [jbf_pkg::CRC_W-1:0] crc_i,
  input  wire logic [DW-1:0]             data_i,
  // Updated parity
  output logic      [jbf_pkg::CRC_W-1:0] crc_o
);

  // The polynomial constant keeps the top term and drops the +1 term, so the
  // feedback taps are that constant moved up one place with the +1 term put back.
  localparam logic [jbf_pkg::CRC_W-1:0] TAPS = {jbf_pkg::CRC_POLY[jbf_pkg::CRC_W-2:0], 1'b1};

  logic [jbf_pkg::CRC_W-1:0] acc;
  logic                      fb;

  // Bit 0 of the data enters first, as it leaves the lane first.
  always_comb begin
    acc = crc_i;
    fb  = 1'b0;
    for (int j = 0; j < DW; j++) begin
      fb  = acc[jbf_pkg::CRC_W-1] ^ data_i[j];
      acc = {acc[jbf_pkg::CRC_W-2:0], 1'b0} ^ (fb ? TAPS : jbf_pkg::CRC_INIT);
    end
    crc_o = acc;
  end

endmodule // jbf_crc12_step

//--- logic/jbf_framer.sv
// Transmit 64B/66B framer: scrambles, adds sync headers, builds the header stream.
// Assumes one payload block per enabled clock and SYSREF arriving as an asynchronous pin.
`timescale 1ns/10ps
module jbf_framer #(
  parameter int EMB_MB       = 1,
  parameter int FRAME_OCTETS = 2
) (
  // Clock, reset and enable
  input  wire logic                          mclk_i,
  input  wire logic                          rstn_i,
  input  wire logic                          ce_i,
  // Timing reference pin
  input  wire logic                          sysref_i,
  // Configuration
  input  wire logic [jbf_pkg::FMT_W-1:0]     header_stream_format_select_i,
  // Payload from the transport layer, octet 0 in the low byte
  input  wire logic [jbf_pkg::PAYLOAD_W-1:0] payload_i,
  // Transmitted block and markers
  output logic      [jbf_pkg::TXBLK_W-1:0]   block_o,
  output logic                               block_valid_o,
  output logic                               lemc_o,
  output logic                               fmt_unsupported_o
);

  localparam int MB_W = (EMB_MB > 1) ? $clog2(EMB_MB) : 1;
  localparam logic [MB_W-1:0] MB_LAST = MB_W'(EMB_MB - 1);
  localparam int MB_BITS = jbf_pkg::MB_BLOCKS * jbf_pkg::PAYLOAD_W / jbf_pkg::OCTETS;

  // An extended multiblock must hold whole frames, and E must be 1 when one multiblock does.
  if (EMB_MB < 1 || FRAME_OCTETS < 1) begin : g_bad_size
    $error("jbf_framer: EMB_MB and FRAME_OCTETS must be positive");
  end
  if ((MB_BITS * EMB_MB) % FRAME_OCTETS != 0) begin : g_bad_frames
    $error("jbf_framer: extended multiblock does not hold whole frames");
  end
  if (EMB_MB > 1 && (MB_BITS % FRAME_OCTETS) == 0) begin : g_bad_e
    $error("jbf_framer: E must be 1 when a multiblock holds whole frames");
  end

  typedef struct packed {
    logic                           sync_a;
    logic                           sync_b;
    logic                           sync_c;
    logic [jbf_pkg::BLK_W-1:0]      blk;
    logic [MB_W-1:0]                mb;
    logic [jbf_pkg::CRC_W-1:0]      crc;
    logic [jbf_pkg::CRC_W-1:0]      par;
    logic [jbf_pkg::SCR_W-1:0]      scr;
    logic [jbf_pkg::TXBLK_W-1:0]    tx;
    logic                           valid;
    logic                           lemc;
    logic                           fmt_bad;
    logic [jbf_pkg::BLK_W-1:0]      out_blk;
    logic [MB_W-1:0]                out_mb;
    logic                           out_crc;
  } jbf_state_t;

  jbf_state_t                       state_reg;
  jbf_state_t                       state_next;
  logic                             sref_edge;
  logic                             fmt_crc;
  logic                             emb_last;
  logic                             hdr_bit;
  logic [jbf_pkg::SCR_W-1:0]        scr_st;
  logic                             scr_bit;
  logic [jbf_pkg::PAYLOAD_W-1:0]    scr_data;
  logic [jbf_pkg::SHS_W-1:0]        shs_word;
  logic [jbf_pkg::CRC_W-1:0]        crc_step;

  jbf_crc12_step #(
    .DW     (jbf_pkg::PAYLOAD_W)
  ) u_crc (
    .crc_i  (state_reg.crc),
    .data_i (scr_data),
    .crc_o  (crc_step)
  );

  always_comb begin
    state_next = state_reg;
    // Two flip-flops bring the pin in; a third gives the edge.
    state_next.sync_a = sysref_i;
    state_next.sync_b = state_reg.sync_a;
    state_next.sync_c = state_reg.sync_b;
    sref_edge = state_reg.sync_b & ~state_reg.sync_c;

    // Self-synchronous scrambler, one bit at a time in lane order.
    scr_st   = state_reg.scr;
    scr_bit  = 1'b0;
    scr_data = '0;
    for (int j = 0; j < jbf_pkg::PAYLOAD_W; j++) begin
      scr_bit     = payload_i[j] ^ scr_st[jbf_pkg::SCR_TAP_A-1] ^ scr_st[jbf_pkg::SCR_TAP_B-1];
      scr_data[j] = scr_bit;
      scr_st      = {scr_st[jbf_pkg::SCR_W-2:0], scr_bit};
    end
    state_next.scr = scr_st;

    // Unknown format codes fall back to CRC-12 and raise a flag.
    fmt_crc = (header_stream_format_select_i != jbf_pkg::FMT_FEC);
    state_next.fmt_bad = (header_stream_format_select_i != jbf_pkg::FMT_CRC12) &&
                         (header_stream_format_select_i != jbf_pkg::FMT_FEC);
    emb_last = (state_reg.mb == MB_LAST);

    // Stream word of the current multiblock; FEC parity positions stay zero here.
    if (fmt_crc) begin
      shs_word = jbf_pkg::SHS_CRC12_TMPL;
      for (int g = 0; g < jbf_pkg::CRC_GROUPS; g++) begin
        for (int k = 0; k < jbf_pkg::CRC_GROUP_BITS; k++) begin
          shs_word[g*jbf_pkg::CRC_GROUP_STRIDE + k] =
            state_reg.par[jbf_pkg::CRC_W-1 - g*jbf_pkg::CRC_GROUP_BITS - k];
        end
      end
    end else begin
      shs_word = jbf_pkg::SHS_FEC_TMPL;
    end
    shs_word[jbf_pkg::POS_EOEMB] = emb_last;

    // Header 01 (bit 0 low, bit 1 high) sends a one.
    hdr_bit = shs_word[state_reg.blk];
    state_next.tx = {scr_data, hdr_bit, ~hdr_bit};

    // Parity clears at each border and is captured after the last block.
    if (state_reg.blk == jbf_pkg::BLK_LAST) begin
      state_next.crc = jbf_pkg::CRC_INIT;
      state_next.par = crc_step;
    end else begin
      state_next.crc = crc_step;
    end

    // Block and multiblock counters form the local extended multiblock clock.
    if (state_reg.blk == jbf_pkg::BLK_LAST) begin
      state_next.blk = '0;
      state_next.mb  = emb_last ? '0 : state_reg.mb + 1'b1;
    end else begin
      state_next.blk = state_reg.blk + 1'b1;
    end
    // A SYSREF edge restarts the count, so the next block opens an extended multiblock.
    if (sref_edge) begin
      state_next.blk = '0;
      state_next.mb  = '0;
      state_next.crc = jbf_pkg::CRC_INIT;
    end

    state_next.lemc    = emb_last && (state_reg.blk == jbf_pkg::BLK_LAST);
    state_next.out_blk = state_reg.blk;
    state_next.out_mb  = state_reg.mb;
    state_next.out_crc = fmt_crc;
    state_next.valid   = 1'b1;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= '0;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  assign block_o           = state_reg.tx;
  assign block_valid_o     = state_reg.valid;
  assign lemc_o            = state_reg.lemc;
  assign fmt_unsupported_o = state_reg.fmt_bad;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  a_header_differs: assert property (
    block_valid_o |-> (block_o[jbf_pkg::SH_POS] != block_o[jbf_pkg::SH_POS+1])
  ) else $error("sync header bits are equal");

  a_eomb_one: assert property (
    block_valid_o && (state_reg.out_blk == jbf_pkg::BLK_LAST) |-> block_o[1] && !block_o[0]
  ) else $error("last block of multiblock does not send a one");

  a_eomb_zeros: assert property (
    block_valid_o && (state_reg.out_blk >= 5'(jbf_pkg::POS_EOMB - jbf_pkg::EOMB_ZEROS)) &&
    (state_reg.out_blk != jbf_pkg::BLK_LAST) |-> !block_o[1]
  ) else $error("end of multiblock zeros missing");

  a_eoemb_bit: assert property (
    block_valid_o && (state_reg.out_blk == 5'(jbf_pkg::POS_EOEMB)) |->
      (block_o[1] == (state_reg.out_mb == MB_LAST))
  ) else $error("end of extended multiblock bit wrong");

  a_pilot_ones: assert property (
    block_valid_o && state_reg.out_crc && jbf_pkg::SHS_CRC12_TMPL[state_reg.out_blk] |-> block_o[1]
  ) else $error("fixed pilot one missing");

  a_cmd_zero: assert property (
    block_valid_o && state_reg.out_crc && jbf_pkg::SHS_CMD_MASK[state_reg.out_blk] |-> !block_o[1]
  ) else $error("command bit not zero");

  a_parity_first: assert property (
    block_valid_o && state_reg.out_crc && (state_reg.out_blk == '0) |->
      (block_o[1] == state_reg.par[jbf_pkg::CRC_W-1])
  ) else $error("parity msb not in first block");

  a_crc_cleared: assert property (
    (state_reg.blk == '0) |-> (state_reg.crc == jbf_pkg::CRC_INIT)
  ) else $error("parity stages not cleared at multiblock start");

  a_sysref_align: assert property (
    ce_i && sref_edge |=> (state_reg.blk == '0) && (state_reg.mb == '0)
  ) else $error("extended multiblock not aligned to SYSREF edge");

  // The block taken at the SYSREF edge keeps its old index; the next one opens the count.
  a_sysref_first: assert property (
    ce_i && sref_edge ##1 ce_i |=> (state_reg.out_blk == '0)
  ) else $error("block after SYSREF edge is not block 0");

  a_lemc_border: assert property (
    $rose(lemc_o) |-> (state_reg.out_blk == jbf_pkg::BLK_LAST) && (state_reg.out_mb == MB_LAST)
  ) else $error("clock edge not at extended multiblock border");

  a_mb_wrap: assert property (
    ce_i && (state_reg.blk == jbf_pkg::BLK_LAST) && !sref_edge |=> (state_reg.blk == '0)
  ) else $error("multiblock is not 32 blocks");

  // Counting, freezing and the local extended multiblock clock.
  a_valid_hold: assert property (
    block_valid_o |=> block_valid_o
  ) else $error("block valid dropped outside reset");

  a_blk_step: assert property (
    ce_i && (state_reg.blk != jbf_pkg::BLK_LAST) && !sref_edge |=>
      (state_reg.blk == $past(state_reg.blk) + 1'b1)
  ) else $error("block index did not advance by one");

  // While the enable is low nothing moves, so the phase against SYSREF is kept.
  a_blk_freeze: assert property (
    !ce_i |=> $stable(state_reg.blk) && $stable(state_reg.mb)
  ) else $error("block count moved while enable was low");

  a_out_freeze: assert property (
    !ce_i |=> $stable(block_o) && $stable(lemc_o)
  ) else $error("outputs moved while enable was low");

  a_mb_step: assert property (
    ce_i && (state_reg.blk == jbf_pkg::BLK_LAST) && (state_reg.mb != MB_LAST) && !sref_edge |=>
      (state_reg.mb == $past(state_reg.mb) + 1'b1)
  ) else $error("multiblock index did not advance at border");

  a_emb_wrap: assert property (
    ce_i && (state_reg.blk == jbf_pkg::BLK_LAST) && (state_reg.mb == MB_LAST) |=>
      (state_reg.mb == '0)
  ) else $error("extended multiblock longer than E multiblocks");

  a_lemc_every: assert property (
    block_valid_o && (state_reg.out_blk == jbf_pkg::BLK_LAST) && (state_reg.out_mb == MB_LAST) |->
      lemc_o
  ) else $error("extended multiblock border without clock mark");

  a_lemc_once: assert property (
    lemc_o && ce_i |=> !lemc_o
  ) else $error("clock mark longer than one block");

  // Parity word: it only moves when the last block of a multiblock is taken, so a cut
  // multiblock leaves the last complete value in place.
  a_crc_running: assert property (
    ce_i && (state_reg.blk != jbf_pkg::BLK_LAST) && !sref_edge |=>
      (state_reg.crc == $past(crc_step))
  ) else $error("running parity lost a block");

  a_parity_capture: assert property (
    ce_i && (state_reg.blk == jbf_pkg::BLK_LAST) |=> (state_reg.par == $past(crc_step))
  ) else $error("parity word not captured after the last block");

  a_parity_hold: assert property (
    !(ce_i && (state_reg.blk == jbf_pkg::BLK_LAST)) |=> $stable(state_reg.par)
  ) else $error("parity word changed inside a multiblock");

  a_parity_bits: assert property (
    block_valid_o && state_reg.out_crc &&
      (int'(state_reg.out_blk) < jbf_pkg::CRC_GROUPS * jbf_pkg::CRC_GROUP_STRIDE) &&
      (int'(state_reg.out_blk) % jbf_pkg::CRC_GROUP_STRIDE < jbf_pkg::CRC_GROUP_BITS) |->
      (block_o[jbf_pkg::SH_POS+1] ==
        state_reg.par[jbf_pkg::CRC_W - 1 - int'(state_reg.out_blk) % jbf_pkg::CRC_GROUP_STRIDE -
          int'(state_reg.out_blk) / jbf_pkg::CRC_GROUP_STRIDE * jbf_pkg::CRC_GROUP_BITS])
  ) else $error("parity bit in wrong stream position");

  // Header stream formats and the flag for codes that are not served.
  a_fec_zeros: assert property (
    block_valid_o && !state_reg.out_crc && (int'(state_reg.out_blk) != jbf_pkg::POS_EOEMB) &&
      (state_reg.out_blk != jbf_pkg::BLK_LAST) |-> !block_o[jbf_pkg::SH_POS+1]
  ) else $error("unexpected one in forward error correction stream");

  a_fmt_crc: assert property (
    ce_i && (header_stream_format_select_i != jbf_pkg::FMT_FEC) |=> state_reg.out_crc
  ) else $error("format code did not select CRC-12");

  a_fmt_fec: assert property (
    ce_i && (header_stream_format_select_i == jbf_pkg::FMT_FEC) |=> !state_reg.out_crc
  ) else $error("format code two did not select forward error correction");

  a_unsup_set: assert property (
    ce_i && (header_stream_format_select_i != jbf_pkg::FMT_CRC12) &&
      (header_stream_format_select_i != jbf_pkg::FMT_FEC) |=> fmt_unsupported_o
  ) else $error("unserved format code not flagged");

  a_unsup_clear: assert property (
    ce_i && ((header_stream_format_select_i == jbf_pkg::FMT_CRC12) ||
      (header_stream_format_select_i == jbf_pkg::FMT_FEC)) |=> !fmt_unsupported_o
  ) else $error("served format code flagged");

  // Block layout and the SYSREF synchroniser.
  a_block_payload: assert property (
    ce_i |=> (block_o[jbf_pkg::TXBLK_W-1:jbf_pkg::OCTET0_POS] == $past(scr_data))
  ) else $error("scrambled octets not in block positions");

  a_header_stream: assert property (
    ce_i |=> (block_o[jbf_pkg::SH_POS+1] == $past(hdr_bit)) && (block_o[jbf_pkg::SH_POS] == !$past(hdr_bit))
  ) else $error("header does not carry the stream bit");

  a_sync_chain: assert property (
    ce_i |=> (state_reg.sync_b == $past(state_reg.sync_a)) &&
      (state_reg.sync_c == $past(state_reg.sync_b))
  ) else $error("SYSREF synchroniser skipped a stage");

  a_sysref_once: assert property (
    ce_i && sref_edge |=> !sref_edge
  ) else $error("SYSREF edge seen twice in a row");

endmodule // jbf_framer

//--- tb/jbf_rx_model.sv
// Receiver model for the framer lane: header check, multiblock search and parity compare.
// Assumes a block is taken on each edge that follows a clock-enabled edge of the framer.
`timescale 1ns/10ps
module jbf_rx_model (
  // Clock and lane
  input  wire logic        mclk_i,
  input  wire logic        ce_i,
  input  wire logic        valid_i,
  input  wire logic [65:0] block_i,
  // Parity compare enable, low outside CRC-12 traffic
  input  wire logic        chk_en_i,
  // Counts
  output logic      [31:0] hdr_err_o,
  output logic      [31:0] crc_err_o,
  output logic      [31:0] n_mb_o
);
  logic        ce_q = 1'b0;
  logic        prev_ok = 1'b0;
  logic [31:0] hist = 32'h0;
  logic [11:0] calc = 12'h000;
  logic [11:0] prev = 12'h000;
  logic [11:0] got;
  int          len = 0;

  initial begin
    hdr_err_o = 32'h0;
    crc_err_o = 32'h0;
    n_mb_o = 32'h0;
  end

  // A multiblock cut short by realignment is never used as a parity reference.
  always @(posedge mclk_i) begin
    if (ce_q && valid_i) begin
      if (block_i[0] == block_i[1]) hdr_err_o++;
      hist = {block_i[1], hist[31:1]};
      for (int j = 2; j < 66; j++)
        calc = {calc[10:0], 1'b0} ^ ((calc[11] ^ block_i[j]) ? 12'h30f : 12'h000);
      len++;
      if (!chk_en_i) begin
        prev_ok = 1'b0;
      end else if (hist[31:27] == 5'h10) begin
        got = {hist[0], hist[1], hist[2], hist[4], hist[5], hist[6],
               hist[8], hist[9], hist[10], hist[12], hist[13], hist[14]};
        if (prev_ok && len == 32) begin
          n_mb_o++;
          if (got != prev) crc_err_o++;
        end
        prev_ok = (len == 32);
        prev = calc;
        calc = 12'h000;
        len = 0;
      end
    end
    ce_q = ce_i;
  end
endmodule // jbf_rx_model

//--- tb/jbf_framer_tb_top.sv
// Testbench top for the block framer: random blocks, enable gaps, format codes and SYSREF.
// Assumes the framer package, the framer and the receiver model are compiled before it.
`timescale 1ns/10ps
module jbf_framer_tb_top;
  localparam int E = 3;
  typedef struct {logic [65:0] blk; logic lemc; logic unsup;} jbf_note_t;
  logic        mclk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        ce_i = 1'b0;
  logic        sysref_i = 1'b0;
  logic        chk_en = 1'b1;
  logic [1:0]  fmt = 2'h0;
  logic [63:0] payload = 64'h0;
  logic [63:0] rng = 64'h1b;
  logic [65:0] block_o;
  logic        valid, lemc, unsup;
  logic [31:0] hdr_err, crc_err, n_mb;
  logic [57:0] scr = '0;
  logic [11:0] crc = 12'h000;
  logic [11:0] par = 12'h000;
  logic        sa = 1'b0, sb = 1'b0, sc = 1'b0;
  int          blk = 0, mb = 0, n_errors = 0, checks = 0, cycles = 0;
  jbf_note_t   q[$];

  jbf_framer #(.EMB_MB(E), .FRAME_OCTETS(3)) i_jbf_framer (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i), .sysref_i(sysref_i),
    .header_stream_format_select_i(fmt), .payload_i(payload), .block_o(block_o),
    .block_valid_o(valid), .lemc_o(lemc), .fmt_unsupported_o(unsup));
  jbf_rx_model i_jbf_rx_model (
    .mclk_i(mclk_i), .ce_i(ce_i), .valid_i(valid), .block_i(block_o), .chk_en_i(chk_en),
    .hdr_err_o(hdr_err), .crc_err_o(crc_err), .n_mb_o(n_mb));

  always #2.5 mclk_i = ~mclk_i;

  function automatic logic [63:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 7;
    rng ^= rng << 17;
    return rng;
  endfunction

  function automatic logic [31:0] shs(logic [1:0] f, logic [11:0] p, logic eo);
    logic [31:0] w;
    w = 32'h8000_0000;
    w[22] = eo;
    if (f != 2'h2) begin
      w |= 32'h00a8_8888;
      w[2:0] = {p[9], p[10], p[11]};
      w[6:4] = {p[6], p[7], p[8]};
      w[10:8] = {p[3], p[4], p[5]};
      w[14:12] = {p[0], p[1], p[2]};
    end
    return w;
  endfunction

  // Reference framer: notes the block expected just after each enabled edge, from that same edge.
  always @(posedge mclk_i) begin : model
    logic [63:0] s;
    logic [31:0] w;
    logic        rise;
    if (rstn_i && ce_i) begin
      for (int j = 0; j < 64; j++) begin
        s[j] = payload[j] ^ scr[38] ^ scr[57];
        scr = {scr[56:0], s[j]};
        crc = {crc[10:0], 1'b0} ^ ((crc[11] ^ s[j]) ? 12'h30f : 12'h000);
      end
      w = shs(fmt, par, mb == E - 1);
      q.push_back('{{s, w[blk], ~w[blk]}, blk == 31 && mb == E - 1, fmt != 2'h0 && fmt != 2'h2});
      rise = sb & ~sc;
      sc = sb;
      sb = sa;
      sa = sysref_i;
      if (blk == 31) begin
        par = crc;
        crc = 12'h000;
      end
      if (rise) begin
        blk = 0;
        mb = 0;
        crc = 12'h000;
      end else begin
        blk = (blk + 1) % 32;
        if (blk == 0) mb = (mb + 1) % E;
      end
    end
  end

  task automatic check(input logic [65:0] got, input logic [65:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  always @(posedge mclk_i) begin : mon
    jbf_note_t n;
    logic      took;
    took = rstn_i && ce_i;
    #2;
    if (took && q.size() > 0) begin
      n = q.pop_front();
      check(block_o, n.blk);
      check(lemc, n.lemc);
      check(unsup, n.unsup);
      check(valid, 1'b1);
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic run(input int n, input bit gaps, input string nm);
    logic [63:0] r;
    repeat (n) begin
      @(posedge mclk_i);
      #1;
      r = xs();
      payload = r;
      ce_i = !gaps || (r[7:6] != 2'h0);
    end
    $display("test %s done", nm);
  endtask

  initial begin
    repeat (3) @(posedge mclk_i);
    #1;
    rstn_i = 1'b1;
    run(250, 0, "crc12");
    run(250, 1, "enable_gaps");
    fmt = 2'h2;
    chk_en = 1'b0;
    run(120, 0, "fec");
    fmt = 2'h0;
    run(2, 0, "back_to_crc12");
    chk_en = 1'b1;
    for (int c = 1; c < 4; c += 2) begin
      fmt = c[1:0];
      run(100, 0, "unknown_code");
    end
    fmt = 2'h0;
    do begin
      @(posedge mclk_i);
      #1;
    end while (blk != 9);
    sysref_i = 1'b1;
    run(2, 0, "sysref_high");
    sysref_i = 1'b0;
    run(300, 0, "sysref_realign");
    check(hdr_err, 66'h0);
    check(crc_err, 66'h0);
    check(n_mb > 32'h4, 66'h1);
    print_verdict();
  end
endmodule // jbf_framer_tb_top
